// *** rx_pause_classify_handshake.sv ***
// Receive pause frame classifier and nine-channel pause request handshake.
//
// Overview of operation
// (RULE1) Frames classified in order: control check, global pause, priority pause; forward gated.
// (RULE2) Global destination passes if unchecked, unicast match, or fixed group match.
// (RULE3) Source and ethertype tests pass when disabled or equal to programmed value.
// (RULE4) Control opcode passes when disabled or within programmed min..max inclusive.
// (RULE5) Priority stages compare multicast against the programmable group address.
// (RULE6) Control frame is global or priority control, each needing all tests and enable.
// (RULE7) Global pause needs all tests, exact opcode, and its enable.
// (RULE8) Priority pause checked only for control frames that failed global pause.
// (RULE9) Priority pause needs all tests, exact opcode, and its enable.
// (RULE10) Mask, request and acknowledge are nine bits; top bit is global pause.
// (RULE11) Masked channel ignores quanta; otherwise raise request and load timer.
// (RULE12) Clearing mask mid-handshake does not abort; channel finishes normally.
// (RULE13) With acknowledge required, timer holds until user raises acknowledge.
// (RULE14) Timer counts down after acknowledge, or at once when none required.
// (RULE15) Timer expiry clears the channel request.
// (RULE16) Completion on acknowledge drop, or 32 cycles after request clears.
// (RULE17) New pause frame mid-handshake reloads timer and continues.
// (RULE18) Each channel runs its own independent state machine and timer.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps

module rx_pause_classify_handshake
  import rx_pause_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  // Register port.
  input  wire logic [REG_ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]       reg_wr_data,
  input  wire logic                    reg_wr_en,
  input  wire logic                    reg_rd_en,
  output logic [DATA_W-1:0]            reg_rd_data,
  // Parsed receive frame, one-cycle strobe with its fields.
  input  wire logic                    frame_valid,
  input  wire logic [ADDR_W-1:0]       frame_dest,
  input  wire logic [ADDR_W-1:0]       frame_src,
  input  wire logic [ETYPE_W-1:0]      frame_etype,
  input  wire logic [OPCODE_W-1:0]     frame_opcode,
  input  wire logic [NUM_PRIO-1:0]     frame_class_vec,
  input  wire logic [NUM_PRIO*QUANTA_W-1:0] frame_quanta,
  // Classification results, one-cycle pulses.
  output logic                         frame_forward,
  output logic                         frame_is_control,
  output logic                         frame_is_global_pause,
  output logic                         frame_is_priority_pause,
  // Pause handshake with user logic.
  output logic [NUM_CH-1:0]            rx_flow_hold_request,
  input  wire logic [NUM_CH-1:0]       rx_flow_hold_ack
);

  // Software-visible configuration.
  logic [CTRL_W-1:0]          ctrl_q;
  logic [4*STAGE_W-1:0]       check_q;
  logic [ADDR_W-1:0]          pause_dest_unicast_addr;
  logic [ADDR_W-1:0]          pause_dest_group_addr;
  logic [ADDR_W-1:0]          pause_src_addr;
  logic [DATA_W-1:0]          etype_ctl_q;
  logic [DATA_W-1:0]          etype_pau_q;
  logic [DATA_W-1:0]          opc_gcp_q;
  logic [DATA_W-1:0]          opc_pcp_q;
  logic [DATA_W-1:0]          opc_pau_q;
  logic [DATA_W-1:0]          reg_rd_data_q;

  logic                       forward_ctrl_frames;
  logic                       require_user_ack;
  logic [NUM_CH-1:0]          rx_flow_accept_mask;
  logic [STAGE_W-1:0]         cfg_gcp;
  logic [STAGE_W-1:0]         cfg_pcp;
  logic [STAGE_W-1:0]         cfg_gpp;
  logic [STAGE_W-1:0]         cfg_ppp;
  logic                       global_ctrl_src_chk;

  // Classification.
  logic                       global_ctrl;
  logic                       prio_ctrl;
  logic                       is_control;
  logic                       is_global_pause;
  logic                       is_prio_pause;
  logic                       fwd_q;
  logic                       ctrl_q_out;
  logic                       gpause_q;
  logic                       ppause_q;

  // Channels.
  chan_state_t                state_q [NUM_CH];
  logic [QUANTA_W-1:0]        timer_q [NUM_CH];
  logic [DROP_CNT_W-1:0]      drop_cnt_q [NUM_CH];
  logic [NUM_CH-1:0]          hold_req_q;
  logic [NUM_CH-1:0]          busy;
  logic [NUM_CH-1:0]          chan_hit;
  logic [QUANTA_W-1:0]        chan_quanta [NUM_CH];

  // Destination test shared by all four stages.
  function automatic logic dest_pass(input logic [STAGE_W-1:0] cfg,
                                     input logic [ADDR_W-1:0]  dest,
                                     input logic [ADDR_W-1:0]  ucast,
                                     input logic [ADDR_W-1:0]  group);
    dest_pass = (!cfg[CFG_MCAST] && !cfg[CFG_UCAST])
              || (cfg[CFG_UCAST] && (dest == ucast))
              || (cfg[CFG_MCAST] && (dest == group));
  endfunction

  // Source, ethertype, opcode verdict and enable, combined for one stage.
  function automatic logic stage_pass(input logic [STAGE_W-1:0] cfg,
                                      input logic               dest_ok,
                                      input logic               src_eq,
                                      input logic               etype_eq,
                                      input logic               opc_ok);
    stage_pass = dest_ok
               && (!cfg[CFG_SA] || src_eq)
               && (!cfg[CFG_ETYPE] || etype_eq)
               && (!cfg[CFG_OPC] || opc_ok)
               && cfg[CFG_EN];
  endfunction

  // Opcode range check used by the two control stages.
  function automatic logic opc_in_range(input logic [OPCODE_W-1:0] opc,
                                        input logic [DATA_W-1:0]   bounds);
    opc_in_range = (opc >= bounds[OPCODE_W-1:0]) && (opc <= bounds[DATA_W-1:OPCODE_W]);
  endfunction

  // Configuration fields split out of the registers.
  assign forward_ctrl_frames = ctrl_q[CTRL_FWD];
  assign require_user_ack    = ctrl_q[CTRL_ACK];
  assign rx_flow_accept_mask = ctrl_q[CTRL_MASK +: NUM_CH];
  assign cfg_gcp             = check_q[STG_GCP*STAGE_W +: STAGE_W];
  assign cfg_pcp             = check_q[STG_PCP*STAGE_W +: STAGE_W];
  assign cfg_gpp             = check_q[STG_GPP*STAGE_W +: STAGE_W];
  assign cfg_ppp             = check_q[STG_PPP*STAGE_W +: STAGE_W];
  assign global_ctrl_src_chk = cfg_gcp[CFG_SA];

  // Control stage: global and priority control checks are evaluated side by side.
  assign global_ctrl = stage_pass(cfg_gcp, // RULE6
                         dest_pass(cfg_gcp, frame_dest, pause_dest_unicast_addr,
                                   GLOBAL_GROUP_ADDR), // RULE2
                         frame_src == pause_src_addr, // RULE3
                         frame_etype == etype_ctl_q[ETYPE_W-1:0], // RULE3
                         opc_in_range(frame_opcode, opc_gcp_q)); // RULE4
  assign prio_ctrl   = stage_pass(cfg_pcp, // RULE6
                         dest_pass(cfg_pcp, frame_dest, pause_dest_unicast_addr,
                                   pause_dest_group_addr), // RULE5
                         frame_src == pause_src_addr,
                         frame_etype == etype_ctl_q[DATA_W-1:ETYPE_W],
                         opc_in_range(frame_opcode, opc_pcp_q)); // RULE4
  assign is_control  = global_ctrl || prio_ctrl; // RULE6

  // Pause stages run only behind a passed control check, global pause taking priority.
  assign is_global_pause = is_control && stage_pass(cfg_gpp, // RULE1
                         dest_pass(cfg_gpp, frame_dest, pause_dest_unicast_addr,
                                   GLOBAL_GROUP_ADDR), // RULE2
                         frame_src == pause_src_addr,
                         frame_etype == etype_pau_q[ETYPE_W-1:0],
                         frame_opcode == opc_pau_q[OPCODE_W-1:0]); // RULE7
  assign is_prio_pause = is_control && !is_global_pause && stage_pass(cfg_ppp, // RULE8
                         dest_pass(cfg_ppp, frame_dest, pause_dest_unicast_addr,
                                   pause_dest_group_addr), // RULE5
                         frame_src == pause_src_addr,
                         frame_etype == etype_pau_q[DATA_W-1:ETYPE_W],
                         frame_opcode == opc_pau_q[DATA_W-1:OPCODE_W]); // RULE9

  // Classification pulses are registered so the outputs come from flip-flops.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fwd_q      <= 1'b0;
      ctrl_q_out <= 1'b0;
      gpause_q   <= 1'b0;
      ppause_q   <= 1'b0;
    end else begin
      fwd_q      <= frame_valid && (!is_control || forward_ctrl_frames); // RULE1
      ctrl_q_out <= frame_valid && is_control;
      gpause_q   <= frame_valid && is_global_pause;
      ppause_q   <= frame_valid && is_prio_pause;
    end
  end

  // Route a pause frame to its channels: top bit global, low bits one per priority.
  always_comb begin
    for (int i = 0; i < NUM_PRIO; i++) begin
      chan_hit[i]    = frame_valid && is_prio_pause && frame_class_vec[i]; // RULE10
      chan_quanta[i] = frame_quanta[i*QUANTA_W +: QUANTA_W];
    end
    chan_hit[GLOBAL_CH]    = frame_valid && is_global_pause; // RULE10
    chan_quanta[GLOBAL_CH] = frame_quanta[QUANTA_W-1:0];
  end

  // One handshake machine per channel; nothing is shared between channels.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        state_q[i]    <= CH_IDLE;
        timer_q[i]    <= '0;
        drop_cnt_q[i] <= '0;
        hold_req_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin // RULE18
        case (state_q[i])
          CH_IDLE: begin
            // The mask is only looked at here, so clearing it later cannot abort a channel.
            if (chan_hit[i] && rx_flow_accept_mask[i]) begin // RULE11 RULE12
              hold_req_q[i] <= 1'b1;
              timer_q[i]    <= chan_quanta[i];
              state_q[i]    <= require_user_ack ? CH_WAIT_ACK : CH_COUNT; // RULE14
            end
          end
          CH_WAIT_ACK: begin
            if (chan_hit[i]) begin
              timer_q[i] <= chan_quanta[i]; // RULE17
            end
            if (rx_flow_hold_ack[i]) begin
              state_q[i] <= CH_COUNT; // RULE13
            end
          end
          CH_COUNT: begin
            if (chan_hit[i]) begin
              timer_q[i] <= chan_quanta[i]; // RULE17
            end else if (timer_q[i] == '0) begin
              hold_req_q[i] <= 1'b0; // RULE15
              drop_cnt_q[i] <= '0;
              state_q[i]    <= require_user_ack ? CH_WAIT_DROP : CH_IDLE;
            end else begin
              timer_q[i] <= timer_q[i] - 1'b1; // RULE14
            end
          end
          CH_WAIT_DROP: begin
            if (chan_hit[i]) begin
              // A fresh frame restarts the wait without passing through idle.
              hold_req_q[i] <= 1'b1; // RULE17
              timer_q[i]    <= chan_quanta[i];
              state_q[i]    <= CH_WAIT_ACK;
            end else if (!rx_flow_hold_ack[i] || (drop_cnt_q[i] == DROP_CNT_LAST)) begin
              state_q[i] <= CH_IDLE; // RULE16
            end else begin
              drop_cnt_q[i] <= drop_cnt_q[i] + 1'b1; // RULE16
            end
          end
          default: begin
            state_q[i]    <= CH_IDLE;
            hold_req_q[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // Busy view of the channels for the status register.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      busy[i] = (state_q[i] != CH_IDLE);
    end
  end

  // Register writes; the status word is read-only and writes to it are dropped.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q                  <= '0;
      check_q                 <= '0;
      pause_dest_unicast_addr <= RST_ADDR;
      pause_dest_group_addr   <= RST_ADDR;
      pause_src_addr          <= RST_ADDR;
      etype_ctl_q             <= RST_WORD;
      etype_pau_q             <= RST_WORD;
      opc_gcp_q               <= RST_WORD;
      opc_pcp_q               <= RST_WORD;
      opc_pau_q               <= RST_WORD;
    end else if (reg_wr_en) begin
      case (reg_addr)
        OFS_CTRL:      ctrl_q <= reg_wr_data[CTRL_W-1:0];
        OFS_CHECK:     check_q <= reg_wr_data[4*STAGE_W-1:0];
        OFS_UCAST_LO:  pause_dest_unicast_addr[DATA_W-1:0] <= reg_wr_data;
        OFS_UCAST_HI:  pause_dest_unicast_addr[ADDR_W-1:DATA_W] <= reg_wr_data[ADDR_W-DATA_W-1:0];
        OFS_GROUP_LO:  pause_dest_group_addr[DATA_W-1:0] <= reg_wr_data;
        OFS_GROUP_HI:  pause_dest_group_addr[ADDR_W-1:DATA_W] <= reg_wr_data[ADDR_W-DATA_W-1:0];
        OFS_SRC_LO:    pause_src_addr[DATA_W-1:0] <= reg_wr_data;
        OFS_SRC_HI:    pause_src_addr[ADDR_W-1:DATA_W] <= reg_wr_data[ADDR_W-DATA_W-1:0];
        OFS_ETYPE_CTL: etype_ctl_q <= reg_wr_data;
        OFS_ETYPE_PAU: etype_pau_q <= reg_wr_data;
        OFS_OPC_GCP:   opc_gcp_q <= reg_wr_data;
        OFS_OPC_PCP:   opc_pcp_q <= reg_wr_data;
        OFS_OPC_PAU:   opc_pau_q <= reg_wr_data;
        default: begin
        end
      endcase
    end
  end

  // Read data stands for exactly the cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rd_data_q <= RST_WORD;
    end else if (!reg_rd_en) begin
      reg_rd_data_q <= RST_WORD;
    end else begin
      case (reg_addr)
        OFS_CTRL:      reg_rd_data_q <= DATA_W'(ctrl_q);
        OFS_CHECK:     reg_rd_data_q <= DATA_W'(check_q);
        OFS_UCAST_LO:  reg_rd_data_q <= pause_dest_unicast_addr[DATA_W-1:0];
        OFS_UCAST_HI:  reg_rd_data_q <= DATA_W'(pause_dest_unicast_addr[ADDR_W-1:DATA_W]);
        OFS_GROUP_LO:  reg_rd_data_q <= pause_dest_group_addr[DATA_W-1:0];
        OFS_GROUP_HI:  reg_rd_data_q <= DATA_W'(pause_dest_group_addr[ADDR_W-1:DATA_W]);
        OFS_SRC_LO:    reg_rd_data_q <= pause_src_addr[DATA_W-1:0];
        OFS_SRC_HI:    reg_rd_data_q <= DATA_W'(pause_src_addr[ADDR_W-1:DATA_W]);
        OFS_ETYPE_CTL: reg_rd_data_q <= etype_ctl_q;
        OFS_ETYPE_PAU: reg_rd_data_q <= etype_pau_q;
        OFS_OPC_GCP:   reg_rd_data_q <= opc_gcp_q;
        OFS_OPC_PCP:   reg_rd_data_q <= opc_pcp_q;
        OFS_OPC_PAU:   reg_rd_data_q <= opc_pau_q;
        OFS_STATUS:    reg_rd_data_q <= DATA_W'({busy, hold_req_q});
        default:       reg_rd_data_q <= RST_WORD;
      endcase
    end
  end

  // Outputs straight from flip-flops.
  assign reg_rd_data             = reg_rd_data_q;
  assign frame_forward           = fwd_q;
  assign frame_is_control        = ctrl_q_out;
  assign frame_is_global_pause   = gpause_q;
  assign frame_is_priority_pause = ppause_q;
  assign rx_flow_hold_request    = hold_req_q;

endmodule // rx_pause_classify_handshake

// *** rx_pause_pkg.sv ***
// Constants, register map and channel state type for the receive pause block.
package rx_pause_pkg;

  // Channel layout: the top channel serves global pause, the rest one priority each.
  localparam int unsigned NUM_PRIO     = 8;
  localparam int unsigned NUM_CH       = 9;
  localparam int unsigned GLOBAL_CH    = 8;
  localparam int unsigned QUANTA_W     = 16;
  localparam int unsigned ADDR_W       = 48;
  localparam int unsigned ETYPE_W      = 16;
  localparam int unsigned OPCODE_W     = 16;
  localparam int unsigned REG_ADDR_W   = 8;
  localparam int unsigned DATA_W       = 32;

  // Fixed group address used by the global control and global pause checks.
  localparam logic [47:0] GLOBAL_GROUP_ADDR = 48'h0180c2000001;

  // Grace period after the request clears while the acknowledge stays high.
  localparam int unsigned DROP_WAIT_CYCLES = 32;
  localparam int unsigned DROP_CNT_W       = 6;
  localparam logic [5:0]  DROP_CNT_LAST    = 6'(DROP_WAIT_CYCLES - 1);

  // Per-stage check configuration: field positions inside one 6-bit slice.
  localparam int unsigned STAGE_W   = 6;
  localparam int unsigned CFG_EN    = 0;
  localparam int unsigned CFG_MCAST = 1;
  localparam int unsigned CFG_UCAST = 2;
  localparam int unsigned CFG_SA    = 3;
  localparam int unsigned CFG_ETYPE = 4;
  localparam int unsigned CFG_OPC   = 5;
  // Stage slice indices inside the check register.
  localparam int unsigned STG_GCP = 0;
  localparam int unsigned STG_PCP = 1;
  localparam int unsigned STG_GPP = 2;
  localparam int unsigned STG_PPP = 3;

  // Control register fields.
  localparam int unsigned CTRL_FWD  = 0;
  localparam int unsigned CTRL_ACK  = 1;
  localparam int unsigned CTRL_MASK = 2;
  localparam int unsigned CTRL_W    = 11;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CHECK     = 8'h04;
  localparam logic [7:0] OFS_UCAST_LO  = 8'h08;
  localparam logic [7:0] OFS_UCAST_HI  = 8'h0c;
  localparam logic [7:0] OFS_GROUP_LO  = 8'h10;
  localparam logic [7:0] OFS_GROUP_HI  = 8'h14;
  localparam logic [7:0] OFS_SRC_LO    = 8'h18;
  localparam logic [7:0] OFS_SRC_HI    = 8'h1c;
  localparam logic [7:0] OFS_ETYPE_CTL = 8'h20;
  localparam logic [7:0] OFS_ETYPE_PAU = 8'h24;
  localparam logic [7:0] OFS_OPC_GCP   = 8'h28;
  localparam logic [7:0] OFS_OPC_PCP   = 8'h2c;
  localparam logic [7:0] OFS_OPC_PAU   = 8'h30;
  localparam logic [7:0] OFS_STATUS    = 8'h34;

  // Reset values.
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [47:0] RST_ADDR = 48'h000000000000;

  // Handshake state of one pause channel.
  typedef enum logic [3:0] {
    CH_IDLE      = 4'b0001,
    CH_WAIT_ACK  = 4'b0010,
    CH_COUNT     = 4'b0100,
    CH_WAIT_DROP = 4'b1000
  } chan_state_t;

endpackage

// *** rx_pause_checker.sv ***
// Port-level assertions for the receive pause classifier and handshake.
`timescale 1ns/1ps
module rx_pause_checker
  import rx_pause_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst_b,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic                  reg_rd_en,
  input wire logic [DATA_W-1:0]     reg_rd_data,
  input wire logic                  frame_valid,
  input wire logic                  frame_forward,
  input wire logic                  frame_is_control,
  input wire logic                  frame_is_global_pause,
  input wire logic                  frame_is_priority_pause,
  input wire logic [NUM_CH-1:0]     rx_flow_hold_request
);
  // One domain, so clock and reset are given once for every property.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Result pulses are tied to the frame strobe one cycle earlier.
  a_class_after_frame: assert property ((frame_is_control || frame_forward) |-> $past(frame_valid))
    else $error("Classification pulse without a frame.");
  a_fwd_non_ctrl: assert property ($past(frame_valid) && !frame_is_control |-> frame_forward)
    else $error("Ordinary frame was not delivered.");
  a_gpp_needs_ctrl: assert property (frame_is_global_pause |-> frame_is_control)
    else $error("Global pause without control class.");
  a_ppp_after_gpp: assert property (frame_is_priority_pause |-> frame_is_control && !frame_is_global_pause)
    else $error("Priority pause out of order.");
  // A request may only rise on the cycle its pause pulse shows.
  a_grq_cause: assert property ($rose(rx_flow_hold_request[GLOBAL_CH]) |-> frame_is_global_pause)
    else $error("Global request rose without a pause frame.");
  a_prq_cause: assert property (|(rx_flow_hold_request[7:0] & ~$past(rx_flow_hold_request[7:0]))
    |-> frame_is_priority_pause) else $error("Priority request rose without a pause frame.");
  // A hit at expiry reloads the timer, so the request cannot drop then.
  a_fell_no_hit: assert property ($fell(rx_flow_hold_request[GLOBAL_CH]) |-> !frame_is_global_pause)
    else $error("Global request dropped despite a reload.");
  a_status_mirror: assert property ($past(reg_rd_en) && $past(reg_addr) == OFS_STATUS
    |-> reg_rd_data[8:0] == $past(rx_flow_hold_request)) else $error("Status does not mirror requests.");
endmodule // rx_pause_checker

bind rx_pause_classify_handshake rx_pause_checker u_chk (.clock, .rst_b, .reg_addr, .reg_rd_en, .reg_rd_data,
  .frame_valid, .frame_forward, .frame_is_control, .frame_is_global_pause, .frame_is_priority_pause,
  .rx_flow_hold_request);

// *** user_ack_model.sv ***
// Behavioural user logic that acknowledges pause requests.
`timescale 1ns/1ps
module user_ack_model
  import rx_pause_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic [NUM_CH-1:0] rx_flow_hold_request,
  input wire logic              slow,
  input wire logic              stuck,
  output logic     [NUM_CH-1:0] rx_flow_hold_ack
);
  logic [NUM_CH-1:0] dly_q [0:2];

  // Acknowledge one or four cycles after a request; stuck never drops, to reach the grace period.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dly_q <= '{default: '0};
      rx_flow_hold_ack <= '0;
    end else begin
      dly_q[0] <= rx_flow_hold_request;
      for (int i = 1; i < 3; i++) dly_q[i] <= dly_q[i-1];
      rx_flow_hold_ack <= (slow ? dly_q[2] : rx_flow_hold_request) | (stuck ? rx_flow_hold_ack : '0);
    end
  end
endmodule // user_ack_model

// *** rx_pause_classify_handshake_tb.sv ***
// Self-checking bench for the receive pause classifier and handshake.
`timescale 1ns/1ps
module rx_pause_classify_handshake_tb;
  import rx_pause_pkg::*;
  logic        clock, rst_b, reg_wr_en, reg_rd_en, frame_valid, slow, stuck;
  logic        frame_forward, frame_is_control, frame_is_global_pause, frame_is_priority_pause;
  logic [7:0]  reg_addr, frame_class_vec;
  logic [31:0] reg_wr_data, reg_rd_data, e_rd;
  logic [47:0] frame_dest, frame_src;
  logic [15:0] frame_etype, frame_opcode;
  logic [127:0] frame_quanta;
  logic [8:0]  req, ack, m_req;
  logic [3:0]  e_cls;
  logic [31:0] m [0:13];
  int          st [0:8], tmr [0:8], dc [0:8];
  int          failures, num_checks;

  rx_pause_classify_handshake u_dut (.clock, .rst_b, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en, .reg_rd_data,
    .frame_valid, .frame_dest, .frame_src, .frame_etype, .frame_opcode, .frame_class_vec, .frame_quanta,
    .frame_forward, .frame_is_control, .frame_is_global_pause, .frame_is_priority_pause,
    .rx_flow_hold_request(req), .rx_flow_hold_ack(ack));
  user_ack_model u_user (.clock, .rst_b, .rx_flow_hold_request(req), .slow, .stuck, .rx_flow_hold_ack(ack));

  // Free-running 50 MHz clock.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // One classification stage against the mirrored configuration.
  function automatic bit pass(int s);
    logic [5:0]  c;
    logic [47:0] g;
    logic [15:0] et, lo, hi;
    c = m[1][6*s +: 6];
    g = s[0] ? {m[5][15:0], m[4]} : GLOBAL_GROUP_ADDR;
    et = s[0] ? m[8 + s/2][31:16] : m[8 + s/2][15:0];
    lo = s < 2 ? m[10 + s][15:0] : (s[0] ? m[12][31:16] : m[12][15:0]);
    hi = s < 2 ? m[10 + s][31:16] : lo;
    pass = c[0] && ((!c[1] && !c[2]) || (c[2] && frame_dest == {m[3][15:0], m[2]}) || (c[1] && frame_dest == g))
      && (!c[3] || frame_src == {m[7][15:0], m[6]}) && (!c[4] || frame_etype == et)
      && (!c[5] || (frame_opcode >= lo && frame_opcode <= hi));
  endfunction

  // Reference model: snoops the register port, classifies, and steps nine channel handshakes.
  always @(posedge clock or negedge rst_b) begin
    bit ctl, gp, pp, hit;
    logic [15:0] q;
    if (!rst_b) begin
      for (int i = 0; i < 14; i++) m[i] = 32'h0;
      for (int i = 0; i < 9; i++) st[i] = 0;
      m_req = 9'h0;
      e_rd = 32'h0;
      e_cls = 4'h0;
    end else begin
      e_rd = 32'h0;
      if (reg_rd_en && reg_addr == OFS_STATUS) begin
        e_rd[8:0] = m_req;
        for (int i = 0; i < 9; i++) e_rd[9+i] = st[i] != 0;
      end else if (reg_rd_en && reg_addr < OFS_STATUS && reg_addr[1:0] == 2'b00) begin
        e_rd = m[reg_addr[7:2]] & (reg_addr == 8'h00 ? 32'h7ff : reg_addr == 8'h04 ? 32'hffffff
          : (reg_addr < 8'h20 && reg_addr[2]) ? 32'hffff : '1);
      end
      ctl = pass(0) || pass(1);
      gp = ctl && pass(2);
      pp = ctl && !gp && pass(3);
      e_cls = frame_valid ? {!ctl || m[0][0], ctl, gp, pp} : 4'h0;
      for (int i = 0; i < 9; i++) begin
        hit = frame_valid && (i == 8 ? gp : pp && frame_class_vec[i]);
        q = frame_quanta[16*(i%8) +: 16];
        case (st[i])
          0: if (hit && m[0][2+i]) begin
            m_req[i] = 1'b1;
            tmr[i] = q;
            st[i] = m[0][1] ? 1 : 2;
          end
          1: begin
            if (hit) tmr[i] = q;
            if (ack[i]) st[i] = 2;
          end
          2: if (hit) tmr[i] = q;
            else if (tmr[i] == 0) begin
              m_req[i] = 1'b0;
              st[i] = m[0][1] ? 3 : 0;
              dc[i] = 0;
            end else tmr[i]--;
          default: if (hit) begin
              tmr[i] = q;
              m_req[i] = 1'b1;
              st[i] = 1;
            end else if (!ack[i] || dc[i] == 31) st[i] = 0;
            else dc[i]++;
        endcase
      end
      if (reg_wr_en && reg_addr < OFS_STATUS && reg_addr[1:0] == 2'b00) m[reg_addr[7:2]] = reg_wr_data;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Outputs are settled at the falling edge.
  always @(negedge clock) if (rst_b) begin
    chk(req, m_req);
    chk({frame_forward, frame_is_control, frame_is_global_pause, frame_is_priority_pause}, e_cls);
    chk(reg_rd_data, e_rd);
  end

  // Each strobe is followed by one idle cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clock);
    reg_wr_en <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    @(posedge clock);
  endtask

  // One frame slot of mostly matching or boundary fields.
  task automatic frm(input bit v);
    logic [47:0] da [0:2];
    logic [15:0] et [0:3];
    logic [15:0] op [0:5];
    da = '{{m[3][15:0], m[2]}, {m[5][15:0], m[4]}, GLOBAL_GROUP_ADDR};
    et = '{m[8][15:0], m[8][31:16], m[9][15:0], m[9][31:16]};
    op = '{16'h000f, 16'h0010, 16'h0040, 16'h0041, 16'h0101, 16'h0001};
    frame_valid <= v;
    frame_dest <= da[$urandom % 3];
    frame_src <= ($urandom % 4 != 0) ? {m[7][15:0], m[6]} : 48'h0;
    frame_etype <= et[$urandom % 4];
    frame_opcode <= op[$urandom % 6];
    frame_class_vec <= 8'($urandom);
    for (int i = 0; i < 8; i++) frame_quanta[16*i +: 16] <= 16'($urandom % 8);
    @(posedge clock);
  endtask

  task automatic wrap_up();
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    wrap_up();
  end

  initial begin
    failures = 0;
    num_checks = 0;
    {rst_b, reg_wr_en, reg_rd_en, frame_valid, slow, stuck, reg_addr, frame_class_vec, reg_wr_data} = '0;
    {frame_dest, frame_src, frame_etype, frame_opcode, frame_quanta} = '0;
    void'($urandom(32'h01475aae));
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    for (int a = 0; a < 8'h40; a += 4) rd(8'(a));
    for (int a = 8; a < 8'h28; a += 4) wr(8'(a), $urandom);
    wr(OFS_OPC_GCP, 32'h00400010);
    wr(OFS_OPC_PCP, 32'h01010101);
    wr(OFS_OPC_PAU, 32'h01010001);
    wr(OFS_STATUS, 32'hffffffff);
    wr(8'h40, 32'hffffffff);
    for (int a = 0; a < 8'h44; a += 4) rd(8'(a));
    // Random classification with every channel masked off.
    for (int n = 0; n < 400; n++) begin
      if (n % 50 == 0) wr(OFS_CHECK, $urandom | 32'h00041041);
      if (n % 100 == 0) wr(OFS_CTRL, $urandom & 32'h1);
      frm(1'($urandom % 2));
    end
    // Handshakes: no acknowledge, prompt, slow with mask cleared midway, then stuck acknowledge.
    wr(OFS_CHECK, 32'h00051001);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_CTRL, p == 0 ? 32'h7fd : 32'h7ff);
      slow <= p[1];
      stuck <= (p == 3);
      for (int n = 0; n < 200; n++) begin
        if (n == 100 && p == 2) wr(OFS_CTRL, 32'h003);
        frm($urandom % 6 == 0);
      end
      for (int n = 0; n < 80; n++) frm(1'b0);
      rd(OFS_STATUS);
    end
    wrap_up();
  end
endmodule // rx_pause_classify_handshake_tb
